// *** pkg/adcseq_map.svh ***
`ifndef ADCSEQ_MAP_SVH
`define ADCSEQ_MAP_SVH
// Notes on behaviour
// - Track resumes at conversion end until next fall
// - Host allows 100 ns acquisition before fall
// - Result is 10-bit straight binary, 1024 codes
// - Start powered down; power-up takes 1.5 us
// - Start-pin rising edge begins power-up
// - A start-pin falling edge starts a conversion only while tracking and not powered down
// - Host holds start pin low at power-on
// - Falling edge switches track to hold
// - Conversion lasts 2.3 us, then result latched
// - Pin level at completion chooses stay powered
// - High-speed mode keeps power between conversions
// - Start-pin rising edge enables serial port
// - Serial read allowed any time after rise
// - Early read shifts out previous result
// - Running read defers loading new result
// - Host waits 2.3 us before reading current
// - Early fall waits for power-up, then converts
// - Bits appear on serial clock rising edges
// - Ignore clocks after tenth; release on tenth fall

// ----------------------------------------------------------------------
// Timing and format constants
// ----------------------------------------------------------------------
`define ADCSEQ_CLK_NS 10
`define ADCSEQ_POWERUP_NS 1500
`define ADCSEQ_CONV_NS 2300
`define ADCSEQ_ACQ_NS 100
`define ADCSEQ_RES_BITS 10
`define ADCSEQ_FULL_SCALE 1024
`define ADCSEQ_SCLK_HALF 8
`define ADCSEQ_PULSE_CYC 20
`define ADCSEQ_SYNC_MARGIN 6
`define ADCSEQ_FIFO_DEPTH 8
`endif

// *** pkg/adcseq_pkg.sv ***
package adcseq_pkg;
    // Device power state
    typedef enum logic [1:0] {
        ADCSEQ_PWR_OFF,
        ADCSEQ_PWR_UP,
        ADCSEQ_PWR_ON
    } adcseq_pwr_type;

    // Device converter state
    typedef enum logic [1:0] {
        ADCSEQ_CV_TRACK,
        ADCSEQ_CV_PEND,
        ADCSEQ_CV_RUN
    } adcseq_conv_type;

    // Host sequencing state
    typedef enum logic [1:0] {
        ADCSEQ_H_IDLE,
        ADCSEQ_H_RISE,
        ADCSEQ_H_LOW,
        ADCSEQ_H_READ
    } adcseq_host_type;
endpackage

// *** pkg/adcseq_if.sv ***
`timescale 1ns/1ps
interface adcseq_if;
    logic conversion_start_n;
    logic sclk;
    logic dout;
    logic dout_oe;

    // Device end: listens to start and clock, drives data
    modport dev (
        input conversion_start_n,
        input sclk,
        output dout,
        output dout_oe
    );

    // Host end: drives start and clock, reads data
    modport host (
        output conversion_start_n,
        output sclk,
        input dout,
        input dout_oe
    );
endinterface

// *** hw/adcseq_device.sv ***
`timescale 1ns/1ps
`include "adcseq_map.svh"
module adcseq_device #(
    parameter int RES_BITS = `ADCSEQ_RES_BITS
) (
    input wire logic core_clk,
    input wire logic reset,
    adcseq_if.dev link,
    input wire logic [RES_BITS-1:0] analog_input_pos,
    output logic powered,
    output logic tracking,
    output logic converting,
    output logic [RES_BITS-1:0] result
);
    // ------------------------------------------------------------------
    // Derived cycle counts
    // ------------------------------------------------------------------
    localparam int PU_CYC =
        (`ADCSEQ_POWERUP_NS + `ADCSEQ_CLK_NS - 1) / `ADCSEQ_CLK_NS;
    localparam int CONV_CYC =
        (`ADCSEQ_CONV_NS + `ADCSEQ_CLK_NS - 1) / `ADCSEQ_CLK_NS;
    localparam int TW = 12;
    localparam int CW = $clog2(RES_BITS + 1);

    initial begin
        if ((1 << RES_BITS) != `ADCSEQ_FULL_SCALE || PU_CYC >= 4096 ||
            CONV_CYC >= 4096) begin
            $error("adcseq_device: unsupported parameters");
        end
    end

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic cs_m_q, cs_s_q, cs_p_q;
    logic ck_m_q, ck_s_q, ck_p_q;

    // Three flops per pin; edge detection compares the second and third stages
    always_ff @(posedge core_clk) begin
        if (reset) begin
            cs_m_q <= 1'b0;
            cs_s_q <= 1'b0;
            cs_p_q <= 1'b0;
            ck_m_q <= 1'b0;
            ck_s_q <= 1'b0;
            ck_p_q <= 1'b0;
        end else begin
            cs_m_q <= link.conversion_start_n;
            cs_s_q <= cs_m_q;
            cs_p_q <= cs_s_q;
            ck_m_q <= link.sclk;
            ck_s_q <= ck_m_q;
            ck_p_q <= ck_s_q;
        end
    end

    logic cs_rise, cs_fall, ck_rise, ck_fall;
    assign cs_rise = cs_s_q & ~cs_p_q;
    assign cs_fall = ~cs_s_q & cs_p_q;
    assign ck_rise = ck_s_q & ~ck_p_q;
    assign ck_fall = ~ck_s_q & ck_p_q;

    // ------------------------------------------------------------------
    // Sequencer state
    // ------------------------------------------------------------------
    adcseq_pkg::adcseq_pwr_type pwr_q, pwr_d;
    adcseq_pkg::adcseq_conv_type conv_q, conv_d;
    logic [TW-1:0] pu_tmr_q, pu_tmr_d;
    logic [TW-1:0] cv_tmr_q, cv_tmr_d;
    logic [RES_BITS-1:0] hold_q, hold_d;
    logic [RES_BITS-1:0] result_q, result_d;
    logic [RES_BITS-1:0] shreg_q, shreg_d;
    logic load_pend_q, load_pend_d;
    logic [CW-1:0] bit_cnt_q, bit_cnt_d;
    logic port_en_q, port_en_d;
    logic reading_q, reading_d;
    logic dout_q, dout_d;
    logic oe_q, oe_d;

    // Next-state logic for power, conversion and the serial port
    always_comb begin
        pwr_d = pwr_q;
        conv_d = conv_q;
        pu_tmr_d = pu_tmr_q;
        cv_tmr_d = cv_tmr_q;
        hold_d = hold_q;
        result_d = result_q;
        shreg_d = shreg_q;
        load_pend_d = load_pend_q;
        bit_cnt_d = bit_cnt_q;
        port_en_d = port_en_q;
        reading_d = reading_q;
        dout_d = dout_q;
        oe_d = oe_q;

        // Power: off until a rise, then timed warm-up
        case (pwr_q)
            adcseq_pkg::ADCSEQ_PWR_OFF: begin
                if (cs_rise) begin
                    pwr_d = adcseq_pkg::ADCSEQ_PWR_UP;
                    pu_tmr_d = '0;
                end
            end
            adcseq_pkg::ADCSEQ_PWR_UP: begin
                pu_tmr_d = pu_tmr_q + 1'b1;
                if (pu_tmr_q == TW'(PU_CYC - 1)) begin
                    pwr_d = adcseq_pkg::ADCSEQ_PWR_ON;
                end
            end
            default: begin
            end
        endcase

        // Converter: track, hold on fall, convert for a fixed time
        case (conv_q)
            adcseq_pkg::ADCSEQ_CV_TRACK: begin
                if (cs_fall && pwr_q != adcseq_pkg::ADCSEQ_PWR_OFF) begin
                    hold_d = analog_input_pos;
                    cv_tmr_d = '0;
                    if (pwr_q == adcseq_pkg::ADCSEQ_PWR_ON) begin
                        conv_d = adcseq_pkg::ADCSEQ_CV_RUN;
                    end else begin
                        conv_d = adcseq_pkg::ADCSEQ_CV_PEND;
                    end
                end
            end
            adcseq_pkg::ADCSEQ_CV_PEND: begin
                // Warm-up finishes on its own timer before converting
                if (pwr_q == adcseq_pkg::ADCSEQ_PWR_ON) begin
                    conv_d = adcseq_pkg::ADCSEQ_CV_RUN;
                end
            end
            adcseq_pkg::ADCSEQ_CV_RUN: begin
                cv_tmr_d = cv_tmr_q + 1'b1;
                if (cv_tmr_q == TW'(CONV_CYC - 1)) begin
                    conv_d = adcseq_pkg::ADCSEQ_CV_TRACK;
                    result_d = hold_q;
                    if (reading_q) begin
                        load_pend_d = 1'b1;
                    end else begin
                        shreg_d = hold_q;
                    end
                    // Pin high keeps power for the next one
                    if (!cs_s_q) begin
                        pwr_d = adcseq_pkg::ADCSEQ_PWR_OFF;
                    end // else stays ON
                end
            end
            default: begin
                conv_d = adcseq_pkg::ADCSEQ_CV_TRACK;
            end
        endcase

        // Serial port: a rise rearms the bit counter
        if (cs_rise) begin
            bit_cnt_d = '0;
            port_en_d = 1'b1;
            reading_d = 1'b0;
        end else if (ck_rise && port_en_q) begin
            // Shift register still holds the last latched word
            dout_d = shreg_q[(RES_BITS - 1) - int'(bit_cnt_q)];
            oe_d = 1'b1;
            reading_d = 1'b1;
        end else if (ck_fall && reading_q) begin
            bit_cnt_d = bit_cnt_q + 1'b1;
            if (bit_cnt_q == CW'(RES_BITS - 1)) begin
                oe_d = 1'b0;
                port_en_d = 1'b0;
                reading_d = 1'b0;
                if (load_pend_d) begin
                    shreg_d = result_d;
                    load_pend_d = 1'b0;
                end
            end
        end
    end

    // Register stage; device wakes powered down
    always_ff @(posedge core_clk) begin
        if (reset) begin
            pwr_q <= adcseq_pkg::ADCSEQ_PWR_OFF;
            conv_q <= adcseq_pkg::ADCSEQ_CV_TRACK;
            pu_tmr_q <= '0;
            cv_tmr_q <= '0;
            hold_q <= '0;
            result_q <= '0;
            shreg_q <= '0;
            load_pend_q <= 1'b0;
            bit_cnt_q <= '0;
            port_en_q <= 1'b0;
            reading_q <= 1'b0;
            dout_q <= 1'b0;
            oe_q <= 1'b0;
        end else begin
            pwr_q <= pwr_d;
            conv_q <= conv_d;
            pu_tmr_q <= pu_tmr_d;
            cv_tmr_q <= cv_tmr_d;
            hold_q <= hold_d;
            result_q <= result_d;
            shreg_q <= shreg_d;
            load_pend_q <= load_pend_d;
            bit_cnt_q <= bit_cnt_d;
            port_en_q <= port_en_d;
            reading_q <= reading_d;
            dout_q <= dout_d;
            oe_q <= oe_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign link.dout = dout_q;
    assign link.dout_oe = oe_q;
    assign powered = (pwr_q == adcseq_pkg::ADCSEQ_PWR_ON);
    assign tracking = (conv_q == adcseq_pkg::ADCSEQ_CV_TRACK);
    assign converting = (conv_q == adcseq_pkg::ADCSEQ_CV_RUN);
    assign result = result_q;
endmodule

// *** hw/adcseq_host.sv ***
`timescale 1ns/1ps
`include "adcseq_map.svh"
module adcseq_fifo #(
    parameter int WIDTH = `ADCSEQ_RES_BITS,
    parameter int DEPTH = `ADCSEQ_FIFO_DEPTH
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin
            $error("adcseq_fifo: depth must be a power of two >= 2");
        end
    end

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [AW:0] cnt_q, cnt_d;
    logic push, pop;

    assign in_ready = (cnt_q != (AW + 1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data = mem_q[rd_q];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    // Pointer and occupancy update
    always_comb begin
        wr_d = push ? wr_q + 1'b1 : wr_q;
        rd_d = pop ? rd_q + 1'b1 : rd_q;
        cnt_d = cnt_q + (AW + 1)'(push) - (AW + 1)'(pop);
    end

    // Storage is written only, never reset
    always_ff @(posedge core_clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
        end
    end
endmodule

module adcseq_host #(
    parameter int RES_BITS = `ADCSEQ_RES_BITS,
    parameter int FIFO_DEPTH = `ADCSEQ_FIFO_DEPTH
) (
    input wire logic core_clk,
    input wire logic reset,
    adcseq_if.host link,
    input wire logic start,
    input wire logic fast_mode,
    output logic busy,
    output logic word_valid,
    input wire logic word_ready,
    output logic [RES_BITS-1:0] word_data
);
    // ------------------------------------------------------------------
    // Derived cycle counts
    // ------------------------------------------------------------------
    localparam int CK = `ADCSEQ_CLK_NS;
    localparam int PU_CYC = (`ADCSEQ_POWERUP_NS + CK - 1) / CK;
    localparam int CONV_CYC = (`ADCSEQ_CONV_NS + CK - 1) / CK;
    localparam int ACQ_CYC = (`ADCSEQ_ACQ_NS + CK - 1) / CK;
    localparam int FAST_WAIT = CONV_CYC + ACQ_CYC + `ADCSEQ_SYNC_MARGIN;
    localparam int SLOW_WAIT = PU_CYC + FAST_WAIT;
    localparam int TW = 12;
    localparam int CW = $clog2(RES_BITS + 1);
    localparam int DW = 4;

    initial begin
        if (RES_BITS < 1 || SLOW_WAIT >= 4096 ||
            `ADCSEQ_SCLK_HALF >= 16 || `ADCSEQ_PULSE_CYC >= FAST_WAIT) begin
            $error("adcseq_host: unsupported parameters");
        end
    end

    // ------------------------------------------------------------------
    // Data input synchroniser
    // ------------------------------------------------------------------
    logic di_m_q, di_s_q;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            di_m_q <= 1'b0;
            di_s_q <= 1'b0;
        end else begin
            di_m_q <= link.dout;
            di_s_q <= di_m_q;
        end
    end

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    adcseq_pkg::adcseq_host_type st_q, st_d;
    logic cs_q, cs_d;
    logic sclk_q, sclk_d;
    logic fast_q, fast_d;
    logic [TW-1:0] cnt_q, cnt_d;
    logic [DW-1:0] div_q, div_d;
    logic [CW-1:0] bits_q, bits_d;
    logic [RES_BITS-1:0] shin_q, shin_d;
    logic push_q, push_d;
    logic fifo_ready;

    // Next-state logic; a full FIFO holds off the next conversion
    always_comb begin
        st_d = st_q;
        cs_d = cs_q;
        sclk_d = sclk_q;
        fast_d = fast_q;
        cnt_d = cnt_q;
        div_d = div_q;
        bits_d = bits_q;
        shin_d = shin_q;
        push_d = push_q & ~fifo_ready;
        case (st_q)
            adcseq_pkg::ADCSEQ_H_IDLE: begin
                if (start && fifo_ready && !push_q) begin
                    fast_d = fast_mode;
                    cnt_d = cs_q ? TW'(PU_CYC) : '0;
                    if (cs_q) begin
                        // Still powered from a fast cycle
                        cs_d = 1'b0;
                        st_d = adcseq_pkg::ADCSEQ_H_LOW;
                    end else begin
                        cs_d = 1'b1;
                        st_d = adcseq_pkg::ADCSEQ_H_RISE;
                    end
                end
            end
            adcseq_pkg::ADCSEQ_H_RISE: begin
                cnt_d = cnt_q + 1'b1;
                if (cnt_q == TW'(`ADCSEQ_PULSE_CYC - 1)) begin
                    cs_d = 1'b0;
                    cnt_d = '0;
                    st_d = adcseq_pkg::ADCSEQ_H_LOW;
                end
            end
            adcseq_pkg::ADCSEQ_H_LOW: begin
                cnt_d = cnt_q + 1'b1;
                // Pulse rearms the port; fast mode keeps the pin high
                if (cnt_q == TW'(PU_CYC + `ADCSEQ_PULSE_CYC - 1)) begin
                    cs_d = 1'b1;
                end
                if (cnt_q == TW'(PU_CYC + 2 * `ADCSEQ_PULSE_CYC - 1)) begin
                    cs_d = fast_q;
                end
                // Wait covers conversion plus acquisition margin
                if (cnt_q == TW'(SLOW_WAIT - 1)) begin
                    st_d = adcseq_pkg::ADCSEQ_H_READ;
                    div_d = '0;
                    bits_d = '0;
                end
            end
            adcseq_pkg::ADCSEQ_H_READ: begin
                div_d = div_q + 1'b1;
                if (div_q == DW'(`ADCSEQ_SCLK_HALF - 1)) begin
                    div_d = '0;
                    sclk_d = ~sclk_q;
                    if (sclk_q) begin
                        // Sample just before driving the falling edge
                        shin_d = {shin_q[RES_BITS-2:0], di_s_q};
                        bits_d = bits_q + 1'b1;
                        if (bits_q == CW'(RES_BITS - 1)) begin
                            push_d = 1'b1;
                            st_d = adcseq_pkg::ADCSEQ_H_IDLE;
                        end
                    end
                end
            end
            default: begin
                st_d = adcseq_pkg::ADCSEQ_H_IDLE;
            end
        endcase
    end

    // Start pin held low through reset so the device powers up quiet
    always_ff @(posedge core_clk) begin
        if (reset) begin
            st_q <= adcseq_pkg::ADCSEQ_H_IDLE;
            cs_q <= 1'b0;
            sclk_q <= 1'b0;
            fast_q <= 1'b0;
            cnt_q <= '0;
            div_q <= '0;
            bits_q <= '0;
            shin_q <= '0;
            push_q <= 1'b0;
        end else begin
            st_q <= st_d;
            cs_q <= cs_d;
            sclk_q <= sclk_d;
            fast_q <= fast_d;
            cnt_q <= cnt_d;
            div_q <= div_d;
            bits_q <= bits_d;
            shin_q <= shin_d;
            push_q <= push_d;
        end
    end

    adcseq_fifo #(
        .WIDTH(RES_BITS),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .core_clk(core_clk),
        .reset(reset),
        .in_valid(push_q),
        .in_ready(fifo_ready),
        .in_data(shin_q),
        .out_valid(word_valid),
        .out_ready(word_ready),
        .out_data(word_data)
    );

    assign link.conversion_start_n = cs_q;
    assign link.sclk = sclk_q;
    assign busy = (st_q != adcseq_pkg::ADCSEQ_H_IDLE) | push_q;
endmodule

// *** bench/adcseq_assertions.sv ***
`timescale 1ns/1ps
module adcseq_assertions (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic conversion_start_n,
    input wire logic sclk,
    input wire logic dout,
    input wire logic dout_oe,
    input wire logic powered,
    input wire logic tracking,
    input wire logic converting
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    logic pin_q, pin_d;
    logic [8:0] conv_cnt_q, conv_cnt_d;
    logic [8:0] rise_cnt_q, rise_cnt_d;

    // -----------------------------------------------------------------
    // Helper counters
    // -----------------------------------------------------------------
    // rise_cnt_q saturates so a long idle spell never wraps; conv_cnt_q clears when idle
    always_comb begin
        pin_d = conversion_start_n;
        conv_cnt_d = converting ? conv_cnt_q + 9'h001 : 9'h000;
        if (conversion_start_n && !pin_q) begin
            rise_cnt_d = 9'h001;
        end else if (rise_cnt_q == 9'h1ff) begin
            rise_cnt_d = rise_cnt_q;
        end else begin
            rise_cnt_d = rise_cnt_q + 9'h001;
        end
    end

    // Registers only
    always_ff @(posedge core_clk) begin
        if (reset) begin
            pin_q <= 1'b0;
            conv_cnt_q <= 9'h000;
            rise_cnt_q <= 9'h000;
        end else begin
            pin_q <= pin_d;
            conv_cnt_q <= conv_cnt_d;
            rise_cnt_q <= rise_cnt_d;
        end
    end

    // -----------------------------------------------------------------
    // Sequences and properties
    // -----------------------------------------------------------------
    sequence s_start_fall;
        $fell(conversion_start_n) && powered && tracking;
    endsequence

    sequence s_conv_end;
        $fell(converting);
    endsequence

    a_fall_converts: assert property (
        s_start_fall |-> ##[1:4] converting)
        else $error("conversion did not follow start fall");
    a_conv_length: assert property (
        s_conv_end |-> conv_cnt_q == 9'h0e6)
        else $error("conversion length wrong");
    a_track_resume: assert property (s_conv_end |-> tracking)
        else $error("tracking not resumed at end");
    a_hold_excl: assert property (converting |-> !tracking)
        else $error("tracking during conversion");
    a_power_first: assert property (converting |-> powered)
        else $error("conversion while unpowered");
    a_powerup_len: assert property (
        $rose(powered) |-> rise_cnt_q inside {[9'h094:9'h09c]})
        else $error("power-up interval wrong");
    a_mode_choice: assert property (s_conv_end and
        ($past(conversion_start_n, 4) == conversion_start_n) |->
        ##[0:1] (powered == conversion_start_n))
        else $error("power state at completion wrong");
    a_oe_on_rise: assert property (
        $rose(dout_oe) |-> $past(sclk, 3))
        else $error("data enabled without clock rise");
    a_dout_on_rise: assert property (dout_oe && $past(dout_oe) &&
        $changed(dout) |-> $past(sclk, 3))
        else $error("data changed off clock rise");
    a_oe_release: assert property (
        $fell(dout_oe) |-> !$past(sclk, 3))
        else $error("data released off clock fall");
endmodule

// *** bench/adc_conversion_sequencer_tb_top.sv ***
`timescale 1ns/1ps
module adc_conversion_sequencer_tb_top;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic start = 1'b0;
    logic fast_mode = 1'b0;
    logic word_ready = 1'b0;
    logic busy, word_valid, powered, tracking, converting;
    logic powered_b, tracking_b, converting_b;
    logic [9:0] word_data, result, result_b, rd;
    logic [9:0] analog = 10'h000;
    logic [9:0] analog_b = 10'h000;
    logic [9:0] vals [8] = '{10'h000, 10'h3ff, 10'h001, 10'h200,
                             10'h1ff, 10'h2aa, 10'h155, 10'h3fe};
    int n_fail = 0;
    int checks = 0;
    int cycles = 0;
    int t0;
    adcseq_if lnk();
    adcseq_if lnk_b();
    // Released data line floats so a stale bit cannot pass
    wire dout_line = lnk_b.dout_oe ? lnk_b.dout : 1'bz;

    // -----------------------------------------------------------------
    // Instances
    // -----------------------------------------------------------------
    adcseq_device i_adcseq_device (.core_clk(core_clk), .reset(reset),
        .link(lnk.dev), .analog_input_pos(analog), .powered(powered),
        .tracking(tracking), .converting(converting), .result(result));
    adcseq_host i_adcseq_host (.core_clk(core_clk), .reset(reset),
        .link(lnk.host), .start(start), .fast_mode(fast_mode),
        .busy(busy), .word_valid(word_valid), .word_ready(word_ready),
        .word_data(word_data));
    // Second end driven by the bench, outside host timing
    adcseq_device i_adcseq_device_b (.core_clk(core_clk), .reset(reset),
        .link(lnk_b.dev), .analog_input_pos(analog_b),
        .powered(powered_b), .tracking(tracking_b),
        .converting(converting_b), .result(result_b));
    adcseq_assertions i_adcseq_assertions (.core_clk(core_clk),
        .reset(reset), .conversion_start_n(lnk.conversion_start_n),
        .sclk(lnk.sclk), .dout(lnk.dout), .dout_oe(lnk.dout_oe),
        .powered(powered), .tracking(tracking), .converting(converting));

    // -----------------------------------------------------------------
    // Tasks
    // -----------------------------------------------------------------
    task automatic results();
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic cmp1(input logic got, input logic exp, input string m);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: %s got %b", $time, m, got);
        end
    endtask

    task automatic cmp10(input logic [9:0] got, input logic [9:0] exp,
                         input string m);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: %s %h not %h", $time, m, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    // Request one conversion and wait for the host to finish it
    task automatic convert(input logic [9:0] v, input logic f);
        int k;
        k = 0;
        @(posedge core_clk);
        analog <= v;
        fast_mode <= f;
        start <= 1'b1;
        @(posedge core_clk);
        start <= 1'b0;
        tick(2);
        while (busy !== 1'b0 && k < 2000) begin
            @(posedge core_clk);
            k++;
        end
    endtask

    task automatic get_word(input logic [9:0] exp);
        int k;
        k = 0;
        @(negedge core_clk);
        while (word_valid !== 1'b1 && k < 2000) begin
            @(negedge core_clk);
            k++;
        end
        cmp10(word_data, exp, "word");
        @(posedge core_clk);
        word_ready <= 1'b1;
        @(posedge core_clk);
        word_ready <= 1'b0;
    endtask

    task automatic pin_b(input logic v);
        @(posedge core_clk);
        lnk_b.conversion_start_n <= v;
    endtask

    task automatic wait_conv_b(input logic v);
        int k;
        k = 0;
        @(negedge core_clk);
        while (converting_b !== v && k < 1000) begin
            @(negedge core_clk);
            k++;
        end
    endtask

    // Ten clocks of 160 ns, plus extra ones that must be ignored
    task automatic read_b(output logic [9:0] w, input int extra);
        w = 10'h000;
        for (int i = 0; i < 10 + extra; i++) begin
            @(posedge core_clk);
            lnk_b.sclk <= 1'b1;
            tick(7);
            @(negedge core_clk);
            cmp1(lnk_b.dout_oe, i < 10, "port enable");
            if (i < 10) begin
                w = {w[8:0], dout_line};
            end
            @(posedge core_clk);
            lnk_b.sclk <= 1'b0;
            tick(7);
        end
        @(negedge core_clk);
        cmp1(lnk_b.dout_oe, 1'b0, "release");
    endtask

    // -----------------------------------------------------------------
    // Clock, timeout and main sequence
    // -----------------------------------------------------------------
    always #5 core_clk = ~core_clk;

    // Tests need about 7000 cycles
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 25000) begin
            n_fail = n_fail + 1;
            results();
        end
    end

    initial begin
        lnk_b.conversion_start_n = 1'b0;
        lnk_b.sclk = 1'b0;
        tick(5);
        reset <= 1'b0;
        tick(4);
        convert(10'h2a5, 1'b0);
        get_word(10'h2a5);
        cmp10(result, 10'h2a5, "result");
        cmp1(powered, 1'b0, "auto power-down");
        $display("test slow mode done");
        convert(10'h155, 1'b1);
        get_word(10'h155);
        t0 = cycles;
        convert(10'h0aa, 1'b1);
        get_word(10'h0aa);
        cmp1(cycles - t0 < 520, 1'b1, "fast throughput");
        cmp1(powered, 1'b1, "stays powered");
        $display("test fast mode done");
        for (int i = 0; i < 8; i++) begin
            convert(vals[i], i[0]);
        end
        convert(10'h123, 1'b0);
        tick(40);
        cmp1(busy, 1'b0, "start refused when full");
        for (int i = 0; i < 8; i++) begin
            get_word(vals[i]);
        end
        @(negedge core_clk);
        cmp1(word_valid, 1'b0, "buffer empty");
        $display("test buffer done");
        analog_b <= 10'h0c3;
        pin_b(1'b1);
        tick(5);
        pin_b(1'b0);
        t0 = cycles;
        tick(6);
        analog_b <= 10'h3c0;
        wait_conv_b(1'b1);
        cmp1(cycles - t0 >= 140, 1'b1, "early fall waits");
        wait_conv_b(1'b0);
        cmp10(result_b, 10'h0c3, "held sample");
        tick(5);
        cmp1(powered_b, 1'b0, "power-down");
        read_b(rd, 0);
        cmp10(rd, 10'h0c3, "read while down");
        pin_b(1'b1);
        tick(160);
        analog_b <= 10'h21e;
        pin_b(1'b0);
        tick(6);
        read_b(rd, 0);
        cmp10(rd, 10'h0c3, "early read");
        wait_conv_b(1'b0);
        pin_b(1'b1);
        tick(160);
        analog_b <= 10'h0f5;
        pin_b(1'b0);
        tick(20);
        pin_b(1'b1);
        tick(130);
        read_b(rd, 0);
        cmp10(rd, 10'h21e, "read across end");
        cmp10(result_b, 10'h0f5, "new result");
        cmp1(powered_b, 1'b1, "kept powered");
        pin_b(1'b0);
        tick(6);
        pin_b(1'b1);
        tick(4);
        read_b(rd, 2);
        cmp10(rd, 10'h0f5, "deferred load");
        $display("test device timing done");
        results();
    end
endmodule
